// ==== rtl/fcd_regs.svh ====
// constants for the flash command decoder: command codes, fields, timing
// assumes: included by fcd_once_mem and fcd_decoder, definitions only
// Function
// R1: code 0x01 checks all program-flash blocks and the eeprom are erased.
// R2: code 0x02 checks one selected block, program-flash or eeprom, is erased.
// R3: codes 0x03 and 0x10 blank-check a given word count from an address.
// R4: code 0x04 reads back the 64-byte one-time field.
// R5: code 0x06 programs exactly one phrase into program-flash.
// R6: code 0x07 programs the one-time field, each part once only.
// R7: code 0x08 erases everything only with all four protection bits set.
// R8: code 0x09 on program-flash needs low, high disable and open bits set.
// R9: code 0x09 on eeprom needs the eeprom open bit set.
// R10: codes 0x0A and 0x12 erase one program-flash or eeprom sector.
// R11: code 0x11 programs one to four eeprom words.
// R12: code 0x0B erases everything, verifies, then releases security.
// R13: code 0x0C releases security when backdoor keys match.
// R14: code 0x0D sets user margin level for program-flash or eeprom.
// R15: code 0x0E sets field margin level, special modes only.
// R16: code 0x13 overrides protection temporarily once the key matches.
// R17: program-flash normal reads proceed during eeprom program or erase; the code blocks them during an eeprom mass erase.
// R18: disallowed simultaneous access pairs flag an illegal access exception.
// R19: reads stay valid after launch until the array operation starts.
// R20: illegal access raised only in the cycle a read actually collides.
// R21: only one read at a time; arbitrate transparently between arrays.
// R22: any read with a non-normal margin level is a margin read.
// R23: writing one clears the complete flag; set again when command finishes.
// R24: unknown command code is not processed and sets the access error flag.
// R25: permit pflash normal read with eeprom read, margin, program, sector erase; the code flags it while eeprom is busy at a non-normal margin level.
// R26: codes 0x08 and 0x09 count as mass erase.
`ifndef FCD_REGS_SVH
`define FCD_REGS_SVH
`define FCD_CMD_EV_ALL    8'h01
`define FCD_CMD_EV_BLK    8'h02
`define FCD_CMD_EV_PSEC   8'h03
`define FCD_CMD_RD_ONCE   8'h04
`define FCD_CMD_PGM_P     8'h06
`define FCD_CMD_PGM_ONCE  8'h07
`define FCD_CMD_ERS_ALL   8'h08
`define FCD_CMD_ERS_BLK   8'h09
`define FCD_CMD_ERS_PSEC  8'h0A
`define FCD_CMD_UNSECURE  8'h0B
`define FCD_CMD_BACKDOOR  8'h0C
`define FCD_CMD_USR_MRG   8'h0D
`define FCD_CMD_FLD_MRG   8'h0E
`define FCD_CMD_EV_ESEC   8'h10
`define FCD_CMD_PGM_E     8'h11
`define FCD_CMD_ERS_ESEC  8'h12
`define FCD_CMD_PROT_OVR  8'h13
`define FCD_ONCE_BYTES    64
`define FCD_ONCE_PHRASES  8
`define FCD_EE_WORDS_MAX  3'h4
`define FCD_EE_WORDS_MIN  3'h1
`define FCD_MRG_NORMAL    2'h0
`define FCD_LAUNCH_DLY    4'h2
`define FCD_OP_CYCLES     16'h0010
`endif

// ==== rtl/fcd_pkg.sv ====
// types shared by the flash command decoder files
// assumes: fcd_regs.svh on the include path
`default_nettype none
package fcd_pkg;
	typedef enum logic [2:0]
	{
		FCD_IDLE   = 3'b000,
		FCD_LAUNCH = 3'b001,
		FCD_BUSY   = 3'b010,
		FCD_ERASE2 = 3'b011,
		FCD_VERIFY = 3'b100
	} fcd_state_t;
	typedef enum logic [2:0]
	{
		FCD_OP_NONE   = 3'b000,
		FCD_OP_READ   = 3'b001,
		FCD_OP_MARGIN = 3'b010,
		FCD_OP_PGM    = 3'b011,
		FCD_OP_SECT   = 3'b100,
		FCD_OP_MASS   = 3'b101
	} fcd_op_t;
endpackage
`default_nettype wire

// ==== rtl/fcd_once_if.sv ====
// carries one-time field requests between the decoder and its storage
// assumes: both ends on ref_clk
`default_nettype none
interface fcd_once_if;
	logic        wr;
	logic        rd;
	logic [2:0]  idx;
	logic [63:0] wdata;
	logic [63:0] rdata;
	logic        locked;
	modport ctl (output wr, output rd, output idx, output wdata, input rdata, input locked);
	modport mem (input wr, input rd, input idx, input wdata, output rdata, output locked);
endinterface
`default_nettype wire

// ==== rtl/fcd_once_mem.sv ====
// the 64-byte one-time field: eight phrases, each writable once after reset
// assumes: written only through the decoder; contents start erased
`include "fcd_regs.svh"
`default_nettype none
module fcd_once_mem
	import fcd_pkg::*;
#(
	parameter int PHRASES = `FCD_ONCE_PHRASES
)
(
	input  wire logic ref_clk,
	input  wire logic rstn,
	fcd_once_if.mem   bus
);
	logic [63:0]        mem [PHRASES];
	logic [PHRASES-1:0] used;
	logic [PHRASES-1:0] next_used;
	logic [63:0]        rdata;
	logic [63:0]        next_rdata;

	always_comb
	begin
		next_used = used;
		next_rdata = rdata;
		if (bus.wr && !used[bus.idx])
			next_used[bus.idx] = 1'b1; // [R6]
		if (bus.rd)
			next_rdata = used[bus.idx] ? mem[bus.idx] : '1; // [R4]
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			used <= '0;
			rdata <= '1;
		end
		else
		begin
			used <= next_used;
			rdata <= next_rdata;
		end
	end

	// storage itself carries no reset, like the array it stands for
	always_ff @(posedge ref_clk)
	begin
		if (bus.wr && !used[bus.idx])
			mem[bus.idx] <= bus.wdata;
	end

	assign bus.rdata = rdata;
	assign bus.locked = used[bus.idx];
endmodule
`default_nettype wire

// ==== rtl/fcd_decoder.sv ====
// flash command decoder and program-flash/eeprom concurrency checker
// assumes: cpu on ref_clk drives launch and read strobes; array timing abstracted
`include "fcd_regs.svh"
`default_nettype none
module fcd_decoder
	import fcd_pkg::*;
#(
	parameter logic [15:0] OP_CYCLES = `FCD_OP_CYCLES,
	parameter int          KEY_W     = 64
)
(
	input  wire logic             ref_clk,
	input  wire logic             rstn,
	input  wire logic [7:0]       command_code,
	input  wire logic             target_eeprom,
	input  wire logic [2:0]       param_count,
	input  wire logic [2:0]       once_index,
	input  wire logic [63:0]      once_wdata,
	input  wire logic [KEY_W-1:0] key_in,
	input  wire logic [KEY_W-1:0] key_ref,
	input  wire logic [1:0]       margin_level_in,
	input  wire logic             special_mode,
	input  wire logic             low_region_protect_disable,
	input  wire logic             high_region_protect_disable,
	input  wire logic             program_array_protect_open,
	input  wire logic             eeprom_protect_open,
	input  wire logic             command_complete_flag_write_one,
	input  wire logic             access_error_flag_write_one,
	input  wire logic             pflash_rd_req,
	input  wire logic             eeprom_rd_req,
	input  wire logic             pflash_erased,
	input  wire logic             eeprom_erased,
	output logic                  command_complete_flag,
	output logic                  access_error_flag,
	output logic                  check_failed,
	output logic                  illegal_access,
	output logic                  pflash_rd_grant,
	output logic                  eeprom_rd_grant,
	output logic                  security_released,
	output logic                  protect_override,
	output logic [1:0]            pflash_margin,
	output logic [1:0]            eeprom_margin,
	output logic [63:0]           once_rdata,
	output logic                  pflash_array_busy,
	output logic                  eeprom_array_busy,
	output fcd_op_t               pflash_op,
	output fcd_op_t               eeprom_op
);
	fcd_once_if once ();

	fcd_once_mem u_once
	(
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.bus     (once)
	);

	fcd_state_t  state;
	fcd_state_t  next_state;
	logic [7:0]  cmd;
	logic [7:0]  next_cmd;
	logic        tgt_ee;
	logic        next_tgt_ee;
	logic [15:0] cnt;
	logic [15:0] next_cnt;
	logic        next_command_complete_flag;
	logic        next_access_error_flag;
	logic        next_failed;
	logic        next_secrel;
	logic        next_ovr;
	logic [1:0]  next_pmrg;
	logic [1:0]  next_emrg;
	logic        next_pbusy;
	logic        next_ebusy;
	fcd_op_t     next_pop;
	fcd_op_t     next_eop;
	logic        known;
	logic        allowed;
	logic        prot_ok;
	logic        rd_phase;
	logic        pf_read_ok;
	logic        ee_read_ok;
	logic        collide;
	logic        rr_ee;
	logic        next_rr_ee;

	// decode: unknown codes and mode-gated codes never launch
	always_comb
	begin
		known = 1'b1;
		allowed = 1'b1;
		prot_ok = 1'b1;
		unique case (command_code)
			`FCD_CMD_EV_ALL, `FCD_CMD_EV_BLK, `FCD_CMD_EV_PSEC, `FCD_CMD_RD_ONCE,
			`FCD_CMD_PGM_P, `FCD_CMD_PGM_ONCE, `FCD_CMD_ERS_PSEC, `FCD_CMD_BACKDOOR,
			`FCD_CMD_USR_MRG, `FCD_CMD_EV_ESEC, `FCD_CMD_ERS_ESEC, `FCD_CMD_PROT_OVR,
			`FCD_CMD_UNSECURE:
				known = 1'b1;
			`FCD_CMD_PGM_E:
				allowed = (param_count >= `FCD_EE_WORDS_MIN) && (param_count <= `FCD_EE_WORDS_MAX); // [R11]
			`FCD_CMD_FLD_MRG:
				allowed = special_mode; // [R15]
			`FCD_CMD_ERS_ALL:
				prot_ok = low_region_protect_disable && high_region_protect_disable
					&& program_array_protect_open && eeprom_protect_open; // [R7]
			`FCD_CMD_ERS_BLK:
				prot_ok = target_eeprom ? eeprom_protect_open // [R9]
					: (low_region_protect_disable && high_region_protect_disable
					&& program_array_protect_open); // [R8]
			default:
				known = 1'b0; // [R24]
		endcase
	end

	// the array is busy only once the launch window has passed
	always_comb
	begin
		next_state = state;
		next_cmd = cmd;
		next_tgt_ee = tgt_ee;
		next_cnt = cnt;
		next_command_complete_flag = command_complete_flag;
		next_access_error_flag = access_error_flag && !access_error_flag_write_one;
		next_failed = check_failed;
		next_secrel = security_released;
		next_ovr = protect_override;
		next_pmrg = pflash_margin;
		next_emrg = eeprom_margin;
		next_pbusy = 1'b0;
		next_ebusy = 1'b0;
		next_pop = FCD_OP_NONE;
		next_eop = FCD_OP_NONE;
		once.wr = 1'b0;
		once.rd = 1'b0;
		once.idx = once_index;
		once.wdata = once_wdata;
		unique case (state)
			FCD_IDLE:
			begin
				if (command_complete_flag_write_one && command_complete_flag && !access_error_flag)
				begin
					if (!known || !allowed)
						next_access_error_flag = 1'b1; // [R24]
					else
					begin
						next_command_complete_flag = 1'b0; // [R23]
						next_cmd = command_code;
						next_tgt_ee = target_eeprom;
						next_failed = 1'b0;
						next_cnt = {12'h000, `FCD_LAUNCH_DLY};
						next_state = FCD_LAUNCH;
						if (!prot_ok)
						begin
							next_failed = 1'b1;
							next_cnt = 16'h0001;
						end
					end
				end
			end
			FCD_LAUNCH:
			begin
				next_cnt = cnt - 16'h0001; // [R19]
				if (cnt == 16'h0001)
				begin
					next_cnt = OP_CYCLES;
					next_state = check_failed ? FCD_VERIFY : FCD_BUSY;
				end
			end
			FCD_BUSY, FCD_ERASE2:
			begin
				next_cnt = cnt - 16'h0001;
				unique case (cmd)
					`FCD_CMD_ERS_ALL, `FCD_CMD_UNSECURE:
					begin
						next_pbusy = 1'b1;
						next_ebusy = 1'b1;
						next_pop = FCD_OP_MASS; // [R26]
						next_eop = FCD_OP_MASS;
					end
					`FCD_CMD_ERS_BLK:
					begin
						next_pbusy = !tgt_ee;
						next_ebusy = tgt_ee;
						next_pop = tgt_ee ? FCD_OP_NONE : FCD_OP_MASS; // [R26]
						next_eop = tgt_ee ? FCD_OP_MASS : FCD_OP_NONE;
					end
					`FCD_CMD_PGM_P, `FCD_CMD_PGM_ONCE:
					begin
						next_pbusy = 1'b1;
						next_pop = FCD_OP_PGM; // [R5]
					end
					`FCD_CMD_ERS_PSEC:
					begin
						next_pbusy = 1'b1;
						next_pop = FCD_OP_SECT; // [R10]
					end
					`FCD_CMD_PGM_E:
					begin
						next_ebusy = 1'b1;
						next_eop = FCD_OP_PGM; // [R11]
					end
					`FCD_CMD_ERS_ESEC:
					begin
						next_ebusy = 1'b1;
						next_eop = FCD_OP_SECT; // [R10]
					end
					`FCD_CMD_EV_ALL, `FCD_CMD_EV_BLK, `FCD_CMD_EV_PSEC, `FCD_CMD_EV_ESEC:
					begin
						next_pbusy = (cmd == `FCD_CMD_EV_ALL) || (cmd == `FCD_CMD_EV_PSEC)
							|| ((cmd == `FCD_CMD_EV_BLK) && !tgt_ee);
						next_ebusy = (cmd == `FCD_CMD_EV_ALL) || (cmd == `FCD_CMD_EV_ESEC)
							|| ((cmd == `FCD_CMD_EV_BLK) && tgt_ee);
						next_pop = next_pbusy ? FCD_OP_READ : FCD_OP_NONE;
						next_eop = next_ebusy ? FCD_OP_READ : FCD_OP_NONE;
					end
					default:
						next_cnt = 16'h0001;
				endcase
				if (cnt == 16'h0001)
				begin
					next_state = ((cmd == `FCD_CMD_UNSECURE) && (state == FCD_BUSY)) ? FCD_ERASE2 : FCD_VERIFY;
					next_cnt = OP_CYCLES;
				end
			end
			FCD_VERIFY:
			begin
				next_state = FCD_IDLE;
				next_command_complete_flag = 1'b1; // [R23]
				if (!check_failed)
				begin
					unique case (cmd)
						`FCD_CMD_EV_ALL, `FCD_CMD_UNSECURE:
						begin
							next_failed = !(pflash_erased && eeprom_erased); // [R1]
							if (cmd == `FCD_CMD_UNSECURE)
								next_secrel = pflash_erased && eeprom_erased; // [R12]
						end
						`FCD_CMD_EV_BLK:
							next_failed = tgt_ee ? !eeprom_erased : !pflash_erased; // [R2]
						`FCD_CMD_EV_PSEC:
							next_failed = !pflash_erased; // [R3]
						`FCD_CMD_EV_ESEC:
							next_failed = !eeprom_erased; // [R3]
						`FCD_CMD_RD_ONCE:
							once.rd = 1'b1; // [R4]
						`FCD_CMD_PGM_ONCE:
						begin
							next_failed = once.locked; // [R6]
							once.wr = 1'b1;
						end
						`FCD_CMD_BACKDOOR:
						begin
							next_secrel = security_released || (key_in == key_ref); // [R13]
							next_failed = key_in != key_ref;
						end
						`FCD_CMD_PROT_OVR:
						begin
							next_ovr = key_in == key_ref; // [R16]
							next_failed = key_in != key_ref;
						end
						`FCD_CMD_USR_MRG, `FCD_CMD_FLD_MRG:
						begin
							if (tgt_ee)
								next_emrg = margin_level_in; // [R14]
							else
								next_pmrg = margin_level_in; // [R15]
						end
						default:
							next_failed = 1'b0;
					endcase
				end
			end
			default:
				next_state = FCD_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state <= FCD_IDLE;
			cmd <= 8'h00;
			tgt_ee <= 1'b0;
			cnt <= 16'h0000;
			command_complete_flag <= 1'b1;
			access_error_flag <= 1'b0;
			check_failed <= 1'b0;
			security_released <= 1'b0;
			protect_override <= 1'b0;
			pflash_margin <= `FCD_MRG_NORMAL;
			eeprom_margin <= `FCD_MRG_NORMAL;
			pflash_array_busy <= 1'b0;
			eeprom_array_busy <= 1'b0;
			pflash_op <= FCD_OP_NONE;
			eeprom_op <= FCD_OP_NONE;
		end
		else
		begin
			state <= next_state;
			cmd <= next_cmd;
			tgt_ee <= next_tgt_ee;
			cnt <= next_cnt;
			command_complete_flag <= next_command_complete_flag;
			access_error_flag <= next_access_error_flag;
			check_failed <= next_failed;
			security_released <= next_secrel;
			protect_override <= next_ovr;
			pflash_margin <= next_pmrg;
			eeprom_margin <= next_emrg;
			pflash_array_busy <= next_pbusy;
			eeprom_array_busy <= next_ebusy;
			pflash_op <= next_pop;
			eeprom_op <= next_eop;
		end
	end

	// concurrency: only pflash normal reads may overlap eeprom work
	always_comb
	begin
		rd_phase = (pflash_margin != `FCD_MRG_NORMAL) || (eeprom_margin != `FCD_MRG_NORMAL); // [R22]
		pf_read_ok = !pflash_array_busy && !(rd_phase && eeprom_array_busy)
			&& (eeprom_op != FCD_OP_MASS); // [R17] [R25]
		ee_read_ok = !eeprom_array_busy && !pflash_array_busy;
		collide = (pflash_rd_req && !pf_read_ok) || (eeprom_rd_req && !ee_read_ok); // [R18] [R20]
		if (rd_phase && (pflash_array_busy || eeprom_array_busy))
			collide = pflash_rd_req || eeprom_rd_req; // [R22]
	end

	// one read at a time; alternate when both ask so neither starves
	always_comb
	begin
		next_rr_ee = rr_ee;
		pflash_rd_grant = pflash_rd_req && pf_read_ok && !(eeprom_rd_req && ee_read_ok && rr_ee); // [R21]
		eeprom_rd_grant = eeprom_rd_req && ee_read_ok && !pflash_rd_grant; // [R21]
		if (pflash_rd_grant && eeprom_rd_req)
			next_rr_ee = 1'b1;
		else if (eeprom_rd_grant)
			next_rr_ee = 1'b0;
		illegal_access = collide; // [R20]
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			rr_ee <= 1'b0;
		else
			rr_ee <= next_rr_ee;
	end

	assign once_rdata = once.rdata;
endmodule
`default_nettype wire

// ==== verif/fcd_host_model.sv ====
// host side of the decoder: turns a go request into one launch write
// assumes: shares ref_clk and rstn with fcd_decoder; go lasts one cycle
`default_nettype none
module fcd_host_model
(
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	input  wire logic       go,
	input  wire logic [7:0] code_in,
	input  wire logic       command_complete_flag,
	output logic            command_complete_flag_write_one,
	output logic [7:0]      command_code
);
	timeunit 1ns;
	timeprecision 1ps;
	// a write while busy would be lost, so only launch when idle
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			command_complete_flag_write_one <= 1'b0;
			command_code   <= 8'h00;
		end
		else
		begin
			command_complete_flag_write_one <= go && command_complete_flag;
			if (go)
				command_code <= code_in;
		end
	end
endmodule
`default_nettype wire

// ==== verif/fcd_decoder_checker.sv ====
// relations between launch, flags and read arbitration of fcd_decoder
// assumes: bound to fcd_decoder, single clock domain
`default_nettype none
module fcd_decoder_checker
	import fcd_pkg::*;
#(
	parameter logic [15:0] OP_CYCLES = 16'h0010
)
(
	input wire logic       ref_clk,
	input wire logic       rstn,
	input wire logic [7:0] command_code,
	input wire logic       special_mode,
	input wire logic       low_region_protect_disable,
	input wire logic       high_region_protect_disable,
	input wire logic       program_array_protect_open,
	input wire logic       eeprom_protect_open,
	input wire logic       command_complete_flag_write_one,
	input wire logic       pflash_rd_req,
	input wire logic       eeprom_rd_req,
	input wire logic       command_complete_flag,
	input wire logic       access_error_flag,
	input wire logic       illegal_access,
	input wire logic       pflash_rd_grant,
	input wire logic       eeprom_rd_grant,
	input wire logic       pflash_array_busy,
	input wire logic       eeprom_array_busy,
	input wire logic [1:0] pflash_margin,
	input wire logic [1:0] eeprom_margin,
	input wire fcd_op_t    eeprom_op
);
	timeunit 1ns;
	timeprecision 1ps;
	logic launch;
	logic mass_ok;
	logic busy;
	assign launch = command_complete_flag_write_one && command_complete_flag && !access_error_flag;
	assign mass_ok = low_region_protect_disable && high_region_protect_disable && program_array_protect_open
		&& eeprom_protect_open;
	assign busy = pflash_array_busy || eeprom_array_busy;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	a_launch_drops_flag: assert property ($fell(command_complete_flag) |-> $past(command_complete_flag_write_one))
		else $error("complete flag fell without a launch write");
	a_flag_returns: assert property ($fell(command_complete_flag) |-> ##[1:60] command_complete_flag)
		else $error("complete flag did not return");
	a_launch_window: assert property ($fell(command_complete_flag) |-> !busy ##1 !busy)
		else $error("array busy inside launch window");
	a_unknown_code: assert property (launch && !(command_code inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07,
		8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h10, 8'h11, 8'h12, 8'h13})
		|=> access_error_flag && command_complete_flag)
		else $error("unknown code not refused");
	a_field_margin_mode: assert property (launch && command_code == 8'h0E && !special_mode
		|=> access_error_flag)
		else $error("field margin accepted outside special mode");
	a_mass_locked: assert property (launch && command_code == 8'h08 && !mass_ok |=> !busy [*8])
		else $error("protected erase-all started");
	a_pf_read_ok: assert property (pflash_rd_req && !eeprom_rd_req && eeprom_array_busy && !pflash_array_busy
		&& (eeprom_op == FCD_OP_PGM || eeprom_op == FCD_OP_SECT) && pflash_margin == 2'h0
		&& eeprom_margin == 2'h0 |-> pflash_rd_grant && !illegal_access)
		else $error("pflash read blocked during eeprom write");
	a_pf_collide: assert property (pflash_rd_req && pflash_array_busy |-> illegal_access && !pflash_rd_grant)
		else $error("pflash collision not flagged");
	a_ee_collide: assert property (eeprom_rd_req && busy |-> illegal_access && !eeprom_rd_grant)
		else $error("eeprom collision not flagged");
	a_mass_blocks: assert property (pflash_rd_req && eeprom_array_busy && eeprom_op == FCD_OP_MASS
		|-> illegal_access)
		else $error("read allowed during mass erase");
	a_margin_collide: assert property (pflash_rd_req && eeprom_array_busy && pflash_margin != 2'h0
		|-> illegal_access)
		else $error("margin read allowed during eeprom operation");
	a_idle_no_flag: assert property (!busy |-> !illegal_access)
		else $error("illegal access flagged with no busy array");
	a_single_grant: assert property (!(pflash_rd_grant && eeprom_rd_grant))
		else $error("two read grants at once");
endmodule
bind fcd_decoder fcd_decoder_checker #(.OP_CYCLES(OP_CYCLES)) u_chk (.ref_clk, .rstn, .command_code,
	.special_mode, .low_region_protect_disable, .high_region_protect_disable, .program_array_protect_open,
	.eeprom_protect_open, .command_complete_flag_write_one, .pflash_rd_req, .eeprom_rd_req, .command_complete_flag,
	.access_error_flag, .illegal_access, .pflash_rd_grant, .eeprom_rd_grant, .pflash_array_busy,
	.eeprom_array_busy, .pflash_margin, .eeprom_margin, .eeprom_op);
`default_nettype wire

// ==== verif/tb_fcd_decoder.sv ====
// self-checking bench for fcd_decoder, launches through fcd_host_model
// assumes: checker bound separately; short OP_CYCLES keeps the run small
`default_nettype none
module tb_fcd_decoder import fcd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] all_codes [17] = '{8'h01, 8'h02, 8'h03, 8'h10, 8'h07, 8'h04, 8'h06, 8'h0A, 8'h12,
		8'h11, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h13, 8'h09, 8'h08};
	logic ref_clk = 1'b0, rstn = 1'b0, go = 1'b0, target_eeprom = 1'b0, special_mode = 1'b0;
	logic low_region_protect_disable = 1'b0, high_region_protect_disable = 1'b0;
	logic program_array_protect_open = 1'b0, eeprom_protect_open = 1'b0, access_error_flag_write_one = 1'b0;
	logic pflash_rd_req = 1'b0, eeprom_rd_req = 1'b0, pflash_erased = 1'b1, eeprom_erased = 1'b1;
	logic [7:0] code = 8'h00, command_code;
	logic [2:0] param_count = 3'h4, once_index = 3'h0;
	logic [1:0] margin_level_in = 2'h0, pflash_margin, eeprom_margin;
	logic [63:0] once_wdata = 64'h5a5a_0f0f_1234_abcd, key_in = 64'h0123_4567_89ab_cdef, once_rdata;
	logic [63:0] key_ref = 64'h0123_4567_89ab_cdef;
	logic command_complete_flag_write_one, command_complete_flag, access_error_flag, check_failed, illegal_access;
	logic pflash_rd_grant, eeprom_rd_grant, security_released, protect_override, pflash_array_busy;
	logic eeprom_array_busy, g1;
	fcd_op_t pflash_op, eeprom_op;
	int failures = 0, tests_run = 0, cycles = 0;
	always #10 ref_clk = ~ref_clk;
	fcd_host_model host (.ref_clk, .rstn, .go, .code_in(code), .command_complete_flag, .command_complete_flag_write_one,
		.command_code);
	fcd_decoder #(.OP_CYCLES(16'h0004), .KEY_W(64)) DUT (.ref_clk, .rstn, .command_code, .target_eeprom,
		.param_count, .once_index, .once_wdata, .key_in, .key_ref, .margin_level_in, .special_mode,
		.low_region_protect_disable, .high_region_protect_disable, .program_array_protect_open,
		.eeprom_protect_open, .command_complete_flag_write_one, .access_error_flag_write_one, .pflash_rd_req, .eeprom_rd_req,
		.pflash_erased, .eeprom_erased, .command_complete_flag, .access_error_flag, .check_failed,
		.illegal_access, .pflash_rd_grant, .eeprom_rd_grant, .security_released, .protect_override,
		.pflash_margin, .eeprom_margin, .once_rdata, .pflash_array_busy, .eeprom_array_busy, .pflash_op,
		.eeprom_op);
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// returns on the edge that the decoder takes the launch write
	task automatic launch(input logic [7:0] c);
		@(posedge ref_clk);
		go <= 1'b1;
		code <= c;
		@(posedge ref_clk);
		go <= 1'b0;
		@(posedge ref_clk);
	endtask
	// w: 0 pflash busy, 1 eeprom busy, 2 command complete
	task automatic wait_for(input int w);
		repeat (80)
		begin
			@(negedge ref_clk);
			if ((w == 0 && pflash_array_busy === 1'b1) || (w == 1 && eeprom_array_busy === 1'b1)
				|| (w == 2 && command_complete_flag === 1'b1))
				return;
		end
		check(1'b0, 1'b1);
	endtask
	task automatic run_cmd(input logic [7:0] c);
		launch(c);
		wait_for(2);
	endtask
	task automatic pf_read(input logic exp_grant);
		@(posedge ref_clk);
		pflash_rd_req <= 1'b1;
		@(negedge ref_clk);
		check(pflash_rd_grant, exp_grant);
		check(illegal_access, !exp_grant);
		@(posedge ref_clk);
		pflash_rd_req <= 1'b0;
	endtask
	task automatic t_refused(input logic [7:0] c);
		launch(c);
		@(negedge ref_clk);
		check({access_error_flag, command_complete_flag}, 2'b11);
		@(posedge ref_clk);
		access_error_flag_write_one <= 1'b1;
		@(posedge ref_clk);
		access_error_flag_write_one <= 1'b0;
		@(negedge ref_clk);
		check(access_error_flag, 1'b0);
	endtask
	task automatic t_arbitrate();
		@(posedge ref_clk);
		{pflash_rd_req, eeprom_rd_req} <= 2'b11;
		@(negedge ref_clk);
		g1 = pflash_rd_grant;
		check(pflash_rd_grant ^ eeprom_rd_grant, 1'b1);
		@(negedge ref_clk);
		check(pflash_rd_grant, !g1);
		@(posedge ref_clk);
		{pflash_rd_req, eeprom_rd_req} <= 2'b00;
	endtask
	task automatic t_program();
		launch(8'h06);
		@(negedge ref_clk);
		check({command_complete_flag, pflash_array_busy}, 2'b00);
		pf_read(1'b1);
		wait_for(0);
		check(pflash_op, FCD_OP_PGM);
		pf_read(1'b0);
		wait_for(2);
	endtask
	task automatic t_eeprom_write(input logic [7:0] c, input logic exp_grant);
		launch(c);
		wait_for(1);
		pf_read(exp_grant);
		@(posedge ref_clk);
		eeprom_rd_req <= 1'b1;
		@(negedge ref_clk);
		check(illegal_access, 1'b1);
		@(posedge ref_clk);
		eeprom_rd_req <= 1'b0;
		wait_for(2);
	endtask
	task automatic t_mass();
		run_cmd(8'h08);
		check(check_failed, 1'b1);
		@(posedge ref_clk);
		{high_region_protect_disable, program_array_protect_open, eeprom_protect_open} <= 3'b111;
		run_cmd(8'h09);
		check(check_failed, 1'b1);
		@(posedge ref_clk);
		low_region_protect_disable <= 1'b1;
		target_eeprom <= 1'b1;
		launch(8'h09);
		wait_for(1);
		check(eeprom_op, FCD_OP_MASS);
		pf_read(1'b0);
		wait_for(2);
		check(check_failed, 1'b0);
	endtask
	task automatic t_margin();
		@(posedge ref_clk);
		margin_level_in <= 2'h1;
		target_eeprom <= 1'b0;
		run_cmd(8'h0D);
		check(pflash_margin, 2'h1);
		t_eeprom_write(8'h12, 1'b0);
		@(posedge ref_clk);
		margin_level_in <= 2'h0;
		run_cmd(8'h0D);
		t_eeprom_write(8'h12, 1'b1);
	endtask
	task automatic t_all_codes();
		@(posedge ref_clk);
		special_mode <= 1'b1;
		for (int i = 0; i < 17; i++)
		begin
			run_cmd(all_codes[i]);
			check({access_error_flag, check_failed}, 2'b00);
			if (all_codes[i] == 8'h04)
				check(once_rdata, once_wdata);
			if (all_codes[i] == 8'h0C)
				check(security_released, 1'b1);
			if (all_codes[i] == 8'h13)
				check(protect_override, 1'b1);
		end
		run_cmd(8'h07);
		check(check_failed, 1'b1);
		@(posedge ref_clk);
		pflash_erased <= 1'b0;
		run_cmd(8'h01);
		check(check_failed, 1'b1);
		@(posedge ref_clk);
		target_eeprom <= 1'b1;
		run_cmd(8'h02);
		check(check_failed, 1'b0);
		@(posedge ref_clk);
		margin_level_in <= 2'h2;
		run_cmd(8'h0D);
		check(eeprom_margin, 2'h2);
		pf_read(1'b1);
	endtask
	always @(posedge ref_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			failures++;
			end_of_test();
		end
	end
	initial
	begin
		repeat (5) @(posedge ref_clk);
		rstn <= 1'b1;
		@(negedge ref_clk);
		check(command_complete_flag, 1'b1);
		t_refused(8'h05);
		t_refused(8'h0E);
		t_arbitrate();
		t_program();
		t_eeprom_write(8'h11, 1'b1);
		t_mass();
		t_margin();
		t_all_codes();
		end_of_test();
	end
endmodule
`default_nettype wire
